// ==== brop_port.sv ====
// BCD result output port: request-driven, open-collector digit/strobe outputs
// Contract
// - Word driven, strobe on 30 ms after request
// - Single sample: strobe off 40 ms later
// - Single sample: data released 16 ms after
// - Request held: fresh word every 64 ms
// - Hold at word change freezes, never floats
// - Outputs only pull low or float
// - Request and hold inputs active low; measurement valid input active high
module brop_port
   import brop_pkg::*;
#(
   parameter int unsigned DIGITS       = DIGITS_DEF,
   parameter int unsigned BUF_DEPTH    = BUF_DEPTH_DEF,
   parameter int unsigned CNT_W        = CNT_W_DEF,
   parameter int unsigned SETUP_CYC_P  = SETUP_CYC,
   parameter int unsigned STROBE_CYC_P = STROBE_CYC,
   parameter int unsigned TAIL_CYC_P   = TAIL_CYC,
   parameter int unsigned PERIOD_CYC_P = PERIOD_CYC
)(
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   input  wire logic                  request_n_in,     // Pin, low = request
   input  wire logic                  hold_n_in,        // Pin, low = hold word
   input  wire logic                  meas_valid_in,    // New measurement offered
   input  wire logic [DIGITS*4-1:0]   meas_digits_in,   // BCD digits
   input  wire logic                  meas_polarity_in, // Sign
   input  wire logic                  meas_overflow_in, // Over range
   output logic                       meas_ready_out,   // Buffer can take a word
   output logic [DIGITS*4+1:0]        data_level_out,   // Pin level when enabled
   output logic [DIGITS*4+1:0]        data_oe_out,      // Pull low: overflow,sign,digits
   output logic                       valid_level_out,  // Strobe pin level
   output logic                       valid_oe_out      // Pull low: strobe active
);

   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned WW = DIGITS * 4 + 2;
   localparam logic [CNT_W-1:0] SETUP_L  = CNT_W'(SETUP_CYC_P);
   localparam logic [CNT_W-1:0] SS_L     = CNT_W'(SETUP_CYC_P + STROBE_CYC_P);
   localparam logic [CNT_W-1:0] TAIL_L   = CNT_W'(TAIL_CYC_P);
   localparam logic [CNT_W-1:0] PERIOD_L = CNT_W'(PERIOD_CYC_P);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic req_meta_reg;   // First stage, read by second only
   logic req_act_reg;    // Request asserted
   logic hold_meta_reg;
   logic hold_act_reg;   // Hold asserted
   logic req_meta_next;
   logic hold_meta_next;

   // Low level on a contact input means asserted
   always_comb
   begin
      req_meta_next  = ~request_n_in;
      hold_meta_next = ~hold_n_in;
   end

   // Two flops per pin; contacts are asynchronous to the core clock
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         req_meta_reg  <= SYNC_RST;
         req_act_reg   <= SYNC_RST;
         hold_meta_reg <= SYNC_RST;
         hold_act_reg  <= SYNC_RST;
      end
      else
      begin
         req_meta_reg  <= req_meta_next;
         req_act_reg   <= req_meta_reg;
         hold_meta_reg <= hold_meta_next;
         hold_act_reg  <= hold_meta_reg;
      end
   end

   // ==========================================================================
   // Sample buffer
   // ==========================================================================
   logic          buf_valid;  // Buffered word waiting
   logic [WW-1:0] buf_data;
   logic          pop;        // Port takes the word

   // Stalls the producer while the port is not drawing words
   brop_buf #(
      .W     (WW),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (meas_valid_in),
      .in_data_in    ({meas_overflow_in, meas_polarity_in, meas_digits_in}),
      .in_ready_out  (meas_ready_out),
      .out_valid_out (buf_valid),
      .out_data_out  (buf_data),
      .out_ready_in  (pop)
   );

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   brop_state_t   state_reg;   // Transfer phase
   brop_state_t   state_next;
   logic [CNT_W-1:0] cnt_reg;  // Cycles since word change or strobe off
   logic [CNT_W-1:0] cnt_next;
   logic [WW-1:0] word_reg;    // Word presented
   logic [WW-1:0] word_next;
   logic          drive_reg;   // Word lines enabled
   logic          drive_next;
   logic          valid_reg;   // Strobe
   logic          valid_next;
   logic          req_prev_reg; // For request edge detection
   logic [WW-1:0] oe_reg;      // Registered pin enables
   logic [WW-1:0] oe_next;
   logic          take;        // A fresh word may be loaded

   // Next state, count, word and strobe
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = CNT_W'(cnt_reg + 1'b1);
      word_next  = word_reg;
      drive_next = drive_reg;
      valid_next = valid_reg;
      pop        = 1'h0;
      // A held word is kept; an empty buffer also keeps the last word
      take       = !hold_act_reg && buf_valid;
      unique case (state_reg)
         ST_IDLE:
         begin
            cnt_next = '0;
            // Nothing is driven until the reader asks
            if (req_act_reg && !req_prev_reg)
            begin
               state_next = ST_SETUP;
               drive_next = 1'h1;
               if (take)
               begin
                  word_next = buf_data;
                  pop       = 1'h1;
               end
            end
         end
         ST_SETUP:
         begin
            // Word settles while the strobe is off
            if (cnt_reg == SETUP_L - 1'b1)
            begin
               state_next = ST_STROBE;
               valid_next = 1'h1;
            end
         end
         ST_STROBE:
         begin
            if (req_act_reg && cnt_reg == PERIOD_L - 2'h2)
            begin
               // Strobe drops a cycle before the word moves
               state_next = ST_RELOAD;
               valid_next = 1'h0;
            end
            else if (!req_act_reg && cnt_reg >= SS_L - 1'b1)
            begin
               state_next = ST_TAIL;
               valid_next = 1'h0;
               cnt_next   = '0;
            end
         end
         ST_RELOAD:
         begin
            // Lines stay driven across the change, held or not
            state_next = ST_SETUP;
            cnt_next   = '0;
            if (take)
            begin
               word_next = buf_data;
               pop       = 1'h1;
            end
         end
         ST_TAIL:
         begin
            // A new request edge here is lost; idle waits for a fresh edge
            if (cnt_reg == TAIL_L - 1'b1)
            begin
               state_next = ST_IDLE;
               drive_next = 1'h0;
               cnt_next   = '0;
            end
         end
         default:
         begin
            // Illegal one-hot code: return quietly to idle
            state_next = ST_IDLE;
            cnt_next   = '0;
            drive_next = 1'h0;
            valid_next = 1'h0;
         end
      endcase
      // Set bit pulls the line low; clear bit floats it
      oe_next = drive_next ? word_next : '0;
   end

   // Registers only
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_reg    <= ST_IDLE;
         cnt_reg      <= '0;
         word_reg     <= '0;
         drive_reg    <= 1'h0;
         valid_reg    <= 1'h0;
         req_prev_reg <= 1'h0;
         oe_reg       <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         word_reg     <= word_next;
         drive_reg    <= drive_next;
         valid_reg    <= valid_next;
         req_prev_reg <= req_act_reg;
         oe_reg       <= oe_next;
      end
   end

   // ==========================================================================
   // Open-collector pins: level is always low, only the enable moves
   // ==========================================================================
   always_comb
   begin
      data_level_out  = '0;
      valid_level_out = 1'h0;
      data_oe_out     = oe_reg;
      valid_oe_out    = valid_reg;
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   start_on_edge_a: assert property (
      (state_reg == ST_IDLE && req_act_reg && !req_prev_reg)
      |=> (state_reg == ST_SETUP && drive_reg && !valid_oe_out))
      else $error("request edge did not start a transfer");

   setup_delay_a: assert property (
      $rose(valid_oe_out) |-> $past(cnt_reg) == SETUP_L - 1'b1)
      else $error("strobe did not follow the settle time");

   strobe_min_a: assert property (
      (state_reg == ST_STROBE && !req_act_reg && cnt_reg < SS_L - 1'b1
       && cnt_reg != PERIOD_L - 2'h2) |=> valid_oe_out)
      else $error("strobe dropped early in single sample");

   strobe_end_a: assert property (
      (state_reg == ST_STROBE && !req_act_reg && cnt_reg >= SS_L - 1'b1)
      |=> (!valid_oe_out && state_reg == ST_TAIL && cnt_reg == '0))
      else $error("strobe not ended after its width");

   release_time_a: assert property (
      $fell(drive_reg) |-> ($past(state_reg) == ST_TAIL
                            && $past(cnt_reg) == TAIL_L - 1'b1 && data_oe_out == '0))
      else $error("data released at the wrong time");

   period_a: assert property (
      (state_reg == ST_RELOAD) |-> ($past(cnt_reg) == PERIOD_L - 2'h2
                                    ##1 (state_reg == ST_SETUP && cnt_reg == '0)))
      else $error("continuous word period wrong");

   hold_freeze_a: assert property (
      (state_reg == ST_RELOAD && hold_act_reg) |=> ($stable(word_reg) && drive_reg))
      else $error("held word changed at reload");

   no_float_a: assert property (
      (state_reg == ST_RELOAD) |-> (drive_reg ##1 drive_reg))
      else $error("outputs floated between words");

   pull_low_a: assert property (
      (data_level_out == '0 && !valid_level_out)
      && (state_reg != ST_IDLE || (data_oe_out == '0 && !valid_oe_out)))
      else $error("pin driven high or pulled low while idle");

   stable_data_a: assert property (
      (valid_oe_out && $past(valid_oe_out)) |-> $stable(data_oe_out))
      else $error("data moved while strobe active");

   single_c: cover property (
      $rose(valid_oe_out) ##[1:1000] $fell(drive_reg));
   continuous_c: cover property (
      state_reg == ST_RELOAD ##1 state_reg == ST_SETUP);
   hold_reload_c: cover property (state_reg == ST_RELOAD && hold_act_reg);
   buffer_full_c: cover property (!meas_ready_out && meas_valid_in);

endmodule : brop_port

// ==== brop_pkg.sv ====
// Shared constants and types for the BCD result output port
package brop_pkg;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================================
   // Timebase
   // ==========================================================================
   localparam int unsigned CLK_HZ     = 100_000_000;   // Core clock rate
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;  // Cycles in one millisecond

   // ==========================================================================
   // Transfer timing, as printed and in cycles
   // ==========================================================================
   localparam int unsigned SETUP_MS   = 30;  // Request edge to strobe on
   localparam int unsigned STROBE_MS  = 40;  // Strobe width, single sample
   localparam int unsigned TAIL_MS    = 16;  // Strobe off to data release
   localparam int unsigned PERIOD_MS  = 64;  // Word period, continuous output
   localparam int unsigned SETUP_CYC  = SETUP_MS * CYC_PER_MS;
   localparam int unsigned STROBE_CYC = STROBE_MS * CYC_PER_MS;
   localparam int unsigned TAIL_CYC   = TAIL_MS * CYC_PER_MS;
   localparam int unsigned PERIOD_CYC = PERIOD_MS * CYC_PER_MS;

   // ==========================================================================
   // Structure defaults and reset values
   // ==========================================================================
   localparam int unsigned DIGITS_DEF    = 6;      // BCD digits on the port
   localparam int unsigned BUF_DEPTH_DEF = 2;      // Entries in the sample buffer
   localparam int unsigned CNT_W_DEF     = 24;     // Holds the longest count
   localparam logic        SYNC_RST      = 1'h0;   // Synchronised inputs: released

   // ==========================================================================
   // Port sequencer states
   // ==========================================================================
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,  // Outputs floating
      ST_SETUP  = 5'h02,  // Word driven, strobe off
      ST_STROBE = 5'h04,  // Word driven, strobe on
      ST_RELOAD = 5'h08,  // Continuous: strobe off one cycle before next word
      ST_TAIL   = 5'h10   // Single: strobe off, word still driven
   } brop_state_t;

endpackage : brop_pkg

// ==== brop_buf.sv ====
// Small valid/ready buffer between measurement logic and the output port
module brop_buf
   import brop_pkg::*;
#(
   parameter int unsigned W     = 26,
   parameter int unsigned DEPTH = BUF_DEPTH_DEF
)(
   input  wire logic         clk_in,
   input  wire logic         reset_n_in,
   input  wire logic         in_valid_in,   // Producer offers a word
   input  wire logic [W-1:0] in_data_in,
   output logic              in_ready_out,  // Registered: room for a word
   output logic              out_valid_out, // A word is waiting
   output logic [W-1:0]      out_data_out,
   input  wire logic         out_ready_in   // Consumer takes the word
);

   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_L = CW'(DEPTH);

   // ==========================================================================
   // Storage
   // ==========================================================================
   logic [W-1:0]  mem_reg [DEPTH];  // Entries
   logic [PW-1:0] wr_reg;           // Write pointer
   logic [PW-1:0] rd_reg;           // Read pointer
   logic [CW-1:0] cnt_reg;          // Entries held
   logic          rdy_reg;          // Not full
   logic [PW-1:0] wr_next;
   logic [PW-1:0] rd_next;
   logic [CW-1:0] cnt_next;
   logic          rdy_next;
   logic          push;
   logic          pop;

   // Wrap a pointer without relying on a power-of-two depth
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : bump

   // ==========================================================================
   // Pointer and level arithmetic
   // ==========================================================================
   always_comb
   begin
      push     = in_valid_in && rdy_reg;
      pop      = out_ready_in && (cnt_reg != '0);
      wr_next  = push ? bump(wr_reg) : wr_reg;
      rd_next  = pop ? bump(rd_reg) : rd_reg;
      cnt_next = cnt_reg;
      if (push && !pop)
      begin
         cnt_next = CW'(cnt_reg + 1'b1);
      end
      else if (pop && !push)
      begin
         cnt_next = CW'(cnt_reg - 1'b1);
      end
      rdy_next = (cnt_next != FULL_L);  // Back-pressure reaches producer
   end

   // Registers only
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'h1;
      end
      else
      begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   // Data array needs no reset; guarded by the level count
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_reg] <= in_data_in;
      end
   end

   assign in_ready_out  = rdy_reg;
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out  = mem_reg[rd_reg];

endmodule : brop_buf

// ==== brop_reader_model.sv ====
// Reader model: controller that requests and latches words from the BCD port
module brop_reader_model
#(
   parameter int unsigned W = 26  // Digits plus sign plus overflow
)(
   input  wire logic         clk_in,
   input  wire logic         req_cmd_in,     // Bench wants data
   input  wire logic         hold_cmd_in,    // Bench wants the word frozen
   input  wire logic [W-1:0] data_level_in,  // Port pin levels
   input  wire logic [W-1:0] data_oe_in,     // Port pull-low enables
   input  wire logic         valid_level_in, // Strobe pin level
   input  wire logic         valid_oe_in,    // Strobe pull-low enable
   output logic              request_n_out,  // Contact to the port
   output logic              hold_n_out,     // Contact to the port
   output logic [W-1:0]      word_out,       // Word latched at the strobe
   output logic              strobe_out,     // Strobe seen as asserted
   output int                n_words_out     // Words latched so far
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================================
   // Contacts and wired lines
   // ==========================================================================
   logic [W-1:0] data_line;  // Resolved wire, pulled up when released
   logic         strobe_q;   // Strobe one cycle ago

   // Closed contact pulls low, so a request is a low level
   assign request_n_out = ~req_cmd_in;
   assign hold_n_out    = ~hold_cmd_in;

   // A floating open-collector line reads as the pull-up level
   assign data_line  = (data_level_in & data_oe_in) | ~data_oe_in;
   assign strobe_out = ~((valid_level_in & valid_oe_in) | ~valid_oe_in);

   // Counters start clean; the port has no say in them
   initial
   begin
      strobe_q    = 1'b0;
      word_out    = '0;
      n_words_out = 0;
   end

   // Latch only on a fresh strobe; data before it may still settle
   always @(posedge clk_in)
   begin
      strobe_q <= strobe_out;
      if (strobe_out && !strobe_q)
      begin
         word_out    <= ~data_line;
         n_words_out <= n_words_out + 1;
      end
   end
endmodule : brop_reader_model

// ==== testbench.sv ====
// Self-checking bench for the BCD result output port
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t mismatch %h vs %h", $time, (a), (b)); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================================
   // Short counts keep the run brief
   // ==========================================================================
   localparam int SETUP  = 3;
   localparam int STROBE = 4;
   localparam int TAIL   = 2;
   localparam int PERIOD = 20;
   localparam logic [25:0] WA = 26'h2123456;  // Overflow set
   localparam logic [25:0] WB = 26'h1654321;  // Sign set
   localparam logic [25:0] WC = 26'h3999999;
   localparam logic [25:0] WD = 26'h0000102;

   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        req_cmd = 1'b0;
   logic        hold_cmd = 1'b0;
   logic        meas_valid_in = 1'b0;
   logic [23:0] meas_digits_in = 24'h0;
   logic        meas_polarity_in = 1'b0;
   logic        meas_overflow_in = 1'b0;
   wire logic   request_n, hold_n, meas_ready_out, valid_level_out, valid_oe_out, rd_strobe;
   wire logic [25:0] data_level_out, data_oe_out, rd_word;
   int          rd_count;
   int          n_tests = 0;
   int          n_mismatch = 0;
   int          cyc = 0;

   always #5 clk_in = ~clk_in;

   // ==========================================================================
   // Port and reader
   // ==========================================================================
   brop_port #(.SETUP_CYC_P(SETUP), .STROBE_CYC_P(STROBE), .TAIL_CYC_P(TAIL),
      .PERIOD_CYC_P(PERIOD)) uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .request_n_in(request_n), .hold_n_in(hold_n), .meas_valid_in(meas_valid_in),
      .meas_digits_in(meas_digits_in), .meas_polarity_in(meas_polarity_in),
      .meas_overflow_in(meas_overflow_in), .meas_ready_out(meas_ready_out),
      .data_level_out(data_level_out), .data_oe_out(data_oe_out),
      .valid_level_out(valid_level_out), .valid_oe_out(valid_oe_out));

   brop_reader_model #(.W(26)) reader (.clk_in(clk_in), .req_cmd_in(req_cmd),
      .hold_cmd_in(hold_cmd), .data_level_in(data_level_out), .data_oe_in(data_oe_out),
      .valid_level_in(valid_level_out), .valid_oe_in(valid_oe_out),
      .request_n_out(request_n), .hold_n_out(hold_n), .word_out(rd_word),
      .strobe_out(rd_strobe), .n_words_out(rd_count));

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Counts, verdict, end of run
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // One cycle; drops valid once the word was taken, guards against hangs
   task automatic step();
      logic ok;
      ok = meas_valid_in & meas_ready_out;
      @(posedge clk_in);
      #1;
      cyc++;
      if (ok)
      begin
         meas_valid_in = 1'b0;
      end
      if (cyc > 20000)
      begin
         n_mismatch++;
         wrap_up();
      end
   endtask : step

   // Offer one word and hold it until the buffer takes it
   task automatic push(input logic [25:0] w);
      int k;
      step();
      {meas_overflow_in, meas_polarity_in, meas_digits_in} = w;
      meas_valid_in = 1'b1;
      for (k = 0; k < 100 && meas_valid_in; k++)
         step();
      `CHK(meas_valid_in, 1'b0)
   endtask : push

   // Cycles to the next strobe rise; word judged at the rise
   task automatic wait_rise(input logic [25:0] exp, input int exp_n, input bit solid);
      int n;
      n = 0;
      while (valid_oe_out === 1'b1 && n < 200)
      begin
         if (solid) `CHK(data_oe_out !== 26'h0, 1'b1)
         step();
         n++;
      end
      while (valid_oe_out !== 1'b1 && n < 200)
      begin
         if (solid) `CHK(data_oe_out !== 26'h0, 1'b1)
         step();
         n++;
      end
      `CHK(n, exp_n)
      `CHK(rd_strobe, 1'b1)
      `CHK(data_oe_out, exp)
   endtask : wait_rise

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // No request: every line floats
   task automatic t_idle();
      repeat (10)
      begin
         `CHK({valid_oe_out, data_oe_out}, 27'h0)
         `CHK({valid_level_out, data_level_out}, 27'h0)
         step();
      end
   endtask : t_idle

   // Single sample: setup, width, tail, then silence
   task automatic t_single();
      int n;
      push(WA);
      req_cmd = 1'b1;
      n = 0;
      while (data_oe_out === 26'h0 && n < 50)
      begin
         step();
         n++;
      end
      `CHK(n, 3)
      wait_rise(WA, SETUP, 1'b1);
      req_cmd = 1'b0;
      n = 0;
      while (valid_oe_out === 1'b1 && n < 50)
      begin
         `CHK(data_oe_out, WA)
         step();
         n++;
      end
      `CHK(n, STROBE)
      n = 0;
      while (data_oe_out !== 26'h0 && n < 50)
      begin
         step();
         n++;
      end
      `CHK(n, TAIL)
      `CHK(rd_word, WA)
      repeat (30)
      begin
         `CHK({valid_oe_out, data_oe_out}, 27'h0)
         step();
      end
   endtask : t_single

   // Full buffer refuses, then continuous words with a hold in between
   task automatic t_cont();
      int n;
      push(WB);
      push(WC);
      step();
      `CHK(meas_ready_out, 1'b0)
      {meas_overflow_in, meas_polarity_in, meas_digits_in} = WD;
      meas_valid_in = 1'b1;
      repeat (3)
      begin
         step();
         `CHK(meas_ready_out, 1'b0)
      end
      req_cmd = 1'b1;
      wait_rise(WB, SETUP + 3, 1'b0);
      wait_rise(WC, PERIOD, 1'b1);
      hold_cmd = 1'b1;
      wait_rise(WC, PERIOD, 1'b1);
      hold_cmd = 1'b0;
      wait_rise(WD, PERIOD, 1'b1);
      req_cmd = 1'b0;
      n = 0;
      while ((valid_oe_out | (|data_oe_out)) !== 1'b0 && n < 100)
      begin
         step();
         n++;
      end
      `CHK(n < 100, 1'b1)
      `CHK(rd_count, 5)
      `CHK(rd_word, WD)
   endtask : t_cont

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial
   begin
      repeat (2) @(posedge clk_in);
      #1;
      reset_n_in = 1'b1;
      t_idle();
      t_single();
      t_cont();
      wrap_up();
   end
endmodule : testbench
